// ### hdl/lkw_pkg.sv
// Constants, encodings and register map of the link wake and port 2 strap block.
package lkw_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 5000;
  // PHY clock period, 49.152 MHz.
  localparam int PCLK_PERIOD_PS = 20345;
  // Nearest whole count of system clocks per PHY clock.
  localparam int PCLK_DIV_CYCLES = (PCLK_PERIOD_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int WAKE_PERIOD_PCLK = 8;
  localparam int WAKE_HIGH_PCLK = 4;
  localparam int LINK_INACTIVE_TIME_NS = 2600;
  // Least time, rounded up to whole cycles.
  localparam int LINK_INACTIVE_CYCLES =
    (LINK_INACTIVE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] ADR_IRQ = 8'h04;
  localparam logic [ADR_W-1:0] ADR_STATUS = 8'h08;

  // Control register fields.
  localparam int CTRL_LINK_CONTROL = 0;
  localparam int CTRL_RESUME_EN = 1;
  localparam int CTRL_PCLASS_LO = 2;
  localparam int CTRL_PCLASS_HI = 4;

  // Interrupt register fields, write one to clear.
  localparam int IRQ_PORT_EVENT = 0;
  localparam int IRQ_CONFIG_TIMEOUT = 1;
  localparam int IRQ_CABLE_POWER = 2;
  localparam int IRQ_STATE_TIMEOUT = 3;

  // Status register fields, read only.
  localparam int STAT_STRAP = 0;
  localparam int STAT_WAKE = 1;
  localparam int STAT_LINK_ACTIVE = 2;
  localparam int STAT_SENSE_ACTIVE = 3;
  localparam int STAT_PKT_CAUSE = 4;
  localparam int STAT_PWR_CAUSE = 5;

  // Reset values and limits.
  localparam logic LINK_CONTROL_RST = 1'h1;
  localparam logic RESUME_EN_RST = 1'h0;
  localparam logic [2:0] PCLASS_RST = 3'h0;
  localparam logic [2:0] PCLASS_WAKE_MAX = 3'h4;

  // Strap encodings for port 2.
  localparam logic STRAP_BILINGUAL = 1'h0;
  localparam logic STRAP_LEGACY = 1'h1;

  // ==========================================================================
  // States
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_STRAP = 2'b00,
    ST_IDLE = 2'b01,
    ST_WAKE = 2'b10
  } lkw_state_t;

endpackage : lkw_pkg

// ### hdl/lkw_sense_if.sv
// Interface between the core and the link power sense filter.
`timescale 1ns/1ps
interface lkw_sense_if;
  logic sense_raw;
  logic sense_active;

  modport filt (
    input sense_raw,
    output sense_active
  );

  modport core (
    output sense_raw,
    input sense_active
  );
endinterface : lkw_sense_if

// ### hdl/lkw_sense_filter.sv
// Low time filter that judges the link power sense input active or inactive.
`timescale 1ns/1ps
module lkw_sense_filter
  import lkw_pkg::*;
#(
  parameter int INACTIVE_CYCLES = LINK_INACTIVE_CYCLES,
  parameter int CNT_W = $clog2(INACTIVE_CYCLES + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Sense path
  lkw_sense_if.filt sense
);

  typedef struct packed {
    logic [CNT_W-1:0] low_count;
    logic active;
  } lkw_filt_t;

  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(INACTIVE_CYCLES);

  lkw_filt_t st;
  lkw_filt_t next_st;

  // ==========================================================================
  // Filter
  // ==========================================================================
  always_comb begin
    next_st = st;
    // [R12] low time filter
    if (sense.sense_raw) begin
      next_st.low_count = '0;
    end else if (st.low_count != CNT_LIMIT) begin
      next_st.low_count = st.low_count + CNT_W'(1);
    end
    next_st.active = (next_st.low_count != CNT_LIMIT);
  end

  // After reset the sense counts as inactive until it is seen high.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st.low_count <= CNT_LIMIT;
      st.active <= 1'h0;
    end else begin
      st <= next_st;
    end
  end

  assign sense.sense_active = st.active;

endmodule : lkw_sense_filter

// ### hdl/lkw_wake_top.sv
// Port 2 strap capture and link wake output with its Wishbone register file.
//
// Notes on behaviour
// [R01] At reset release sample the pin: 0 bilingual port 2, 1 legacy only.
// [R02] After reset the pin stops being a strap and becomes the wake output.
// [R03] Active wake output is a square wave of eight PHY clock periods.
// [R04] Inactive wake output is driven low; released to high impedance in reset.
// [R05] Wake may only start while the link controller is inactive.
// [R06] A link-on packet for this node starts the wake output.
// [R07] A set port event interrupt bit starts the wake output.
// [R08] Resume enable with config, cable power or state timeout bit starts wake.
// [R09] A power cycle with power class 0 to 4 starts the wake output.
// [R10] Wake keeps toggling until sense is active and the control bit is set.
// [R11] Bus reset stops a wake caused only by a link-on packet.
// [R12] Sense counts inactive after being low longer than about 2.6 us.
// [R13] Link active only when sense active and the control bit is one.
// [R14] Square wave is high four PHY clocks then low four, starting high.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module lkw_wake_top
  import lkw_pkg::*;
#(
  parameter int INACTIVE_CYCLES = LINK_INACTIVE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Dual use pin
  input wire logic wake_link_in,
  output logic wake_link_out,
  output logic wake_link_oe,
  // Strap result
  output logic port2_legacy_strap,
  // Link controller status
  input wire logic link_power_sense,
  output logic link_active,
  // Events from the PHY core
  input wire logic link_on_packet,
  input wire logic bus_reset,
  input wire logic power_cycled,
  input wire logic port_event_set,
  input wire logic config_timeout_set,
  input wire logic cable_power_set,
  input wire logic state_timeout_set
);

  localparam logic [2:0] DIV_LAST = 3'(PCLK_DIV_CYCLES - 1);
  localparam logic [2:0] PHASE_LAST = 3'(WAKE_PERIOD_PCLK - 1);
  localparam logic [2:0] PHASE_HIGH = 3'(WAKE_HIGH_PCLK);

  typedef struct packed {
    lkw_state_t state;
    logic strap;
    logic link_control_bit;
    logic resuming_port_irq_enable;
    logic [2:0] power_class;
    logic port_event_irq;
    logic config_timeout_irq;
    logic cable_power_change_irq;
    logic state_timeout_irq;
    logic pkt_cause;
    logic pwr_cause;
    logic [2:0] div_count;
    logic [2:0] phase;
    logic wake_level;
    logic wake_oe;
    logic ack;
    logic [31:0] rdata;
  } lkw_core_t;

  lkw_core_t st;
  lkw_core_t next_st;

  // ==========================================================================
  // Link power sense filter
  // ==========================================================================
  lkw_sense_if sense_link ();

  assign sense_link.sense_raw = link_power_sense;

  lkw_sense_filter #(
    .INACTIVE_CYCLES(INACTIVE_CYCLES)
  ) u_sense (
    .clk(clk),
    .reset_n(reset_n),
    .sense(sense_link.filt)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic addr_is(input logic [ADR_W-1:0] adr,
                                   input logic [ADR_W-1:0] reg_adr);
    addr_is = (adr == reg_adr);
  endfunction : addr_is

  function automatic logic [31:0] read_word(input lkw_core_t s,
                                            input logic [ADR_W-1:0] adr,
                                            input logic sense_on,
                                            input logic link_on);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr_is(adr, ADR_CTRL)) begin
      w[CTRL_LINK_CONTROL] = s.link_control_bit;
      w[CTRL_RESUME_EN] = s.resuming_port_irq_enable;
      w[CTRL_PCLASS_HI:CTRL_PCLASS_LO] = s.power_class;
    end else if (addr_is(adr, ADR_IRQ)) begin
      w[IRQ_PORT_EVENT] = s.port_event_irq;
      w[IRQ_CONFIG_TIMEOUT] = s.config_timeout_irq;
      w[IRQ_CABLE_POWER] = s.cable_power_change_irq;
      w[IRQ_STATE_TIMEOUT] = s.state_timeout_irq;
    end else if (addr_is(adr, ADR_STATUS)) begin
      w[STAT_STRAP] = s.strap;
      w[STAT_WAKE] = (s.state == ST_WAKE);
      w[STAT_LINK_ACTIVE] = link_on;
      w[STAT_SENSE_ACTIVE] = sense_on;
      w[STAT_PKT_CAUSE] = s.pkt_cause;
      w[STAT_PWR_CAUSE] = s.pwr_cause;
    end
    read_word = w;
  endfunction : read_word

  // ==========================================================================
  // Cause terms
  // ==========================================================================
  logic link_is_active;
  logic irq_cause;
  logic cause_any;
  logic bus_write;
  logic [31:0] wdata;

  // [R13] link active judgement
  assign link_is_active = sense_link.sense_active & st.link_control_bit;

  // [R07] port event cause
  // [R08] timeout cause with resume enable
  assign irq_cause = st.port_event_irq |
                     (st.resuming_port_irq_enable &
                      (st.config_timeout_irq | st.cable_power_change_irq |
                       st.state_timeout_irq));

  assign cause_any = irq_cause | st.pkt_cause | st.pwr_cause;

  // A write takes effect in the cycle whose closing edge sees ack high.
  assign bus_write = wb_cyc & wb_stb & wb_we & st.ack & wb_sel[0];
  assign wdata = wb_dat_w;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_st = st;

    // Bus slave answers every access one cycle after the strobe.
    next_st.ack = wb_cyc & wb_stb & ~st.ack;
    if (wb_cyc & wb_stb & ~st.ack) begin
      next_st.rdata = read_word(st, wb_adr, sense_link.sense_active, link_is_active);
    end

    // Control register writes.
    if (bus_write && addr_is(wb_adr, ADR_CTRL)) begin
      next_st.link_control_bit = wdata[CTRL_LINK_CONTROL];
      next_st.resuming_port_irq_enable = wdata[CTRL_RESUME_EN];
      next_st.power_class = wdata[CTRL_PCLASS_HI:CTRL_PCLASS_LO];
    end

    // Interrupt bits clear on a written one; a new event wins over the clear.
    if (bus_write && addr_is(wb_adr, ADR_IRQ)) begin
      if (wdata[IRQ_PORT_EVENT]) begin
        next_st.port_event_irq = 1'h0;
      end
      if (wdata[IRQ_CONFIG_TIMEOUT]) begin
        next_st.config_timeout_irq = 1'h0;
      end
      if (wdata[IRQ_CABLE_POWER]) begin
        next_st.cable_power_change_irq = 1'h0;
      end
      if (wdata[IRQ_STATE_TIMEOUT]) begin
        next_st.state_timeout_irq = 1'h0;
      end
    end
    if (port_event_set) begin
      next_st.port_event_irq = 1'h1;
    end
    if (config_timeout_set) begin
      next_st.config_timeout_irq = 1'h1;
    end
    if (cable_power_set) begin
      next_st.cable_power_change_irq = 1'h1;
    end
    if (state_timeout_set) begin
      next_st.state_timeout_irq = 1'h1;
    end

    // [R11] packet cause cleared by bus reset
    if (bus_reset || link_is_active) begin
      next_st.pkt_cause = 1'h0;
    end
    // [R06] link-on packet cause
    if (link_on_packet && !link_is_active) begin
      next_st.pkt_cause = 1'h1;
    end

    // [R10] power cause ends when link is active
    if (link_is_active) begin
      next_st.pwr_cause = 1'h0;
    end
    // [R09] power cycle cause
    if (power_cycled && !link_is_active && st.power_class <= PCLASS_WAKE_MAX) begin
      next_st.pwr_cause = 1'h1;
    end

    unique case (st.state)
      ST_STRAP: begin
        // [R01] strap capture at release
        next_st.strap = wake_link_in;
        // [R02] pin turns into wake output
        next_st.state = ST_IDLE;
      end
      ST_IDLE: begin
        // [R05] start only while inactive
        if (!link_is_active && cause_any) begin
          next_st.state = ST_WAKE;
          next_st.div_count = 3'h0;
          next_st.phase = 3'h0;
        end
      end
      ST_WAKE: begin
        // [R03] PHY clock enable divider
        if (st.div_count == DIV_LAST) begin
          next_st.div_count = 3'h0;
          next_st.phase = (st.phase == PHASE_LAST) ? 3'h0 : st.phase + 3'h1;
        end else begin
          next_st.div_count = st.div_count + 3'h1;
        end
        // [R10] stop once link is active
        if (link_is_active) begin
          next_st.state = ST_IDLE;
        // [R11] bus reset drops packet only wake
        end else if (bus_reset && !irq_cause && !st.pwr_cause && !link_on_packet) begin
          next_st.state = ST_IDLE;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase

    // [R14] high four PHY clocks then low four
    next_st.wake_level = (next_st.state == ST_WAKE) && (next_st.phase < PHASE_HIGH);
    // [R04] driven low outside wake, released only in strap phase
    next_st.wake_oe = (next_st.state != ST_STRAP);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st.state <= ST_STRAP;
      st.strap <= STRAP_BILINGUAL;
      st.link_control_bit <= LINK_CONTROL_RST;
      st.resuming_port_irq_enable <= RESUME_EN_RST;
      st.power_class <= PCLASS_RST;
      st.port_event_irq <= 1'h0;
      st.config_timeout_irq <= 1'h0;
      st.cable_power_change_irq <= 1'h0;
      st.state_timeout_irq <= 1'h0;
      st.pkt_cause <= 1'h0;
      st.pwr_cause <= 1'h0;
      st.div_count <= 3'h0;
      st.phase <= 3'h0;
      st.wake_level <= 1'h0;
      st.wake_oe <= 1'h0;
      st.ack <= 1'h0;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign wb_ack = st.ack;
  assign wb_dat_r = st.rdata;
  assign wake_link_out = st.wake_level;
  assign wake_link_oe = st.wake_oe;
  assign port2_legacy_strap = st.strap;
  assign link_active = link_is_active;

endmodule : lkw_wake_top

// ### verification/lkw_wake_props.sv
// Assertion checker for the link wake block, bound to its top module.
`timescale 1ns/1ps
module lkw_wake_props
  import lkw_pkg::*;
#(
  parameter int INACTIVE_CYCLES = LINK_INACTIVE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus and pin
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  input wire logic wake_link_in,
  input wire logic wake_link_out,
  input wire logic wake_link_oe,
  input wire logic port2_legacy_strap,
  // Link state and events
  input wire logic link_power_sense,
  input wire logic link_active,
  input wire logic link_on_packet,
  input wire logic bus_reset
);
  logic [5:0] hi_cnt;
  logic [15:0] lo_cnt;

  // ==========================================================================
  // Run counters
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hi_cnt <= 6'h00;
      lo_cnt <= 16'h0000;
    end else begin
      hi_cnt <= !wake_link_out ? 6'h00 : (hi_cnt == 6'h3F ? hi_cnt : hi_cnt + 6'h01);
      lo_cnt <= link_power_sense ? 16'h0000 : (lo_cnt == 16'hFFFF ? lo_cnt : lo_cnt + 16'h0001);
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence released;
    $rose(reset_n);
  endsequence

  sequence pkt_seen;
    link_on_packet && !link_active && wake_link_oe ##1 (!link_active && !bus_reset) [*2];
  endsequence

  strap_cap_a: assert property (released |=> port2_legacy_strap == $past(wake_link_in))
    else $error("strap not captured at reset release");
  oe_hiz_a: assert property (released |-> !wake_link_oe && !wake_link_out)
    else $error("pin driven during reset");
  oe_on_a: assert property (released |-> ##[1:2] wake_link_oe)
    else $error("pin not driven after reset");
  oe_keep_a: assert property (wake_link_oe |=> wake_link_oe)
    else $error("pin drive dropped");
  link_quiet_a: assert property (link_active |=> !wake_link_out)
    else $error("wake high while link active");
  high_run_a: assert property ($fell(wake_link_out) && !$past(link_active) && !$past(bus_reset)
    |-> int'(hi_cnt) == WAKE_HIGH_PCLK * PCLK_DIV_CYCLES)
    else $error("wake high phase length wrong");
  high_max_a: assert property (int'(hi_cnt) <= WAKE_HIGH_PCLK * PCLK_DIV_CYCLES)
    else $error("wake high phase too long");
  pkt_wake_a: assert property (pkt_seen |-> ##[0:16] wake_link_out)
    else $error("packet did not start wake");
  sense_low_a: assert property (int'(lo_cnt) > INACTIVE_CYCLES + 2 |-> !link_active)
    else $error("link active after long low sense");
  ack_next_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("bus access not acknowledged");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("acknowledge longer than one cycle");

  cover property (pkt_seen);
endmodule : lkw_wake_props

bind lkw_wake_top lkw_wake_props #(.INACTIVE_CYCLES(INACTIVE_CYCLES)) props_u (
  .clk(clk),
  .reset_n(reset_n),
  .wb_cyc(wb_cyc),
  .wb_stb(wb_stb),
  .wb_ack(wb_ack),
  .wake_link_in(wake_link_in),
  .wake_link_out(wake_link_out),
  .wake_link_oe(wake_link_oe),
  .port2_legacy_strap(port2_legacy_strap),
  .link_power_sense(link_power_sense),
  .link_active(link_active),
  .link_on_packet(link_on_packet),
  .bus_reset(bus_reset)
);

// ### verification/lkw_llc_model.sv
// Behavioural model of the link-layer controller power state.
`timescale 1ns/1ps
module lkw_llc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wake pin and bench controls
  input wire logic wake_link_out,
  input wire logic sleep,
  input wire logic [7:0] delay,
  // Power sense toward the device
  output logic link_power_sense
);
  logic powered;
  logic [7:0] cnt;

  // ==========================================================================
  // Power state
  // ==========================================================================
  // powers up on the wake wave
  // A zero delay keeps a sleeping controller asleep whatever the pin does.
  always_ff @(posedge clk) begin
    if (!reset_n || sleep) begin
      powered <= !reset_n;
      cnt <= 8'h00;
    end else if (!powered && delay != 8'h00 && (wake_link_out || cnt != 8'h00)) begin
      cnt <= cnt + 8'h01;
      powered <= (cnt == delay);
    end
  end

  assign link_power_sense = powered;
endmodule : lkw_llc_model

// ### verification/tb_lkw_wake_top.sv
// Self-checking testbench of the link wake and port 2 strap block.
`timescale 1ns/1ps
module tb_lkw_wake_top
  import lkw_pkg::*;
;
  localparam int INACT = 8;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0;
  logic [6:0] ev_v = 7'h00;
  logic sleep = 1'b0, strap_lvl = 1'b0;
  logic [7:0] delay = 8'h00;
  logic [31:0] wb_dat_r, rd;
  logic wb_ack, wake_link_out, wake_link_oe, port2_legacy_strap, wake_link_in;
  logic link_power_sense, link_active, hit;
  logic [2:0] pc;
  int n_fail = 0, num_checks = 0, cycles = 0;
  integer seed = 32'h7A50;

  always #2.5 clk = ~clk;
  assign wake_link_in = wake_link_oe ? wake_link_out : strap_lvl;

  lkw_wake_top #(.INACTIVE_CYCLES(INACT)) dut_u (.clk(clk), .reset_n(reset_n),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hF),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .wake_link_in(wake_link_in),
    .wake_link_out(wake_link_out), .wake_link_oe(wake_link_oe),
    .port2_legacy_strap(port2_legacy_strap), .link_power_sense(link_power_sense),
    .link_active(link_active), .link_on_packet(ev_v[4]), .bus_reset(ev_v[5]),
    .power_cycled(ev_v[6]), .port_event_set(ev_v[0]), .config_timeout_set(ev_v[1]),
    .cable_power_set(ev_v[2]), .state_timeout_set(ev_v[3]));
  lkw_llc_model llc_u (.clk(clk), .reset_n(reset_n), .wake_link_out(wake_link_out),
    .sleep(sleep), .delay(delay), .link_power_sense(link_power_sense));

  function automatic logic exp_irq(input int k, input logic en);
    return (k == 0) || en;
  endfunction : exp_irq
  function automatic logic exp_pwr(input logic [2:0] p);
    return p <= PCLASS_WAKE_MAX;
  endfunction : exp_pwr

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= d;
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  // Pulses one event input: 0-3 irq sets, 4 packet, 5 bus reset, 6 power cycle.
  task automatic ev(input int k);
    @(posedge clk);
    ev_v <= 7'h01 << k;
    @(posedge clk);
    ev_v <= 7'h00;
  endtask : ev

  task automatic watch(input int n);
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk);
      hit = hit | wake_link_out;
    end
  endtask : watch

  task automatic stop_check();
    wb(1'b1, ADR_IRQ, 32'hF);
    wb(1'b1, ADR_CTRL, {27'h0, pc, 2'b01});
    repeat (2) @(negedge clk);
    check("wake_stop", wake_link_out, 1'b0);
  endtask : stop_check

  task automatic rst(input logic s);
    @(posedge clk);
    reset_n <= 1'b0;
    strap_lvl <= s;
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("oe_in_reset", wake_link_oe, 1'b0);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(negedge clk);
    check("strap", port2_legacy_strap, s);
    check("oe_after", wake_link_oe, 1'b1);
    check("out_low", wake_link_out, 1'b0);
    wb(1'b0, ADR_STATUS, 32'h0);
    check("stat_strap", rd[STAT_STRAP], s);
  endtask : rst

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      results();
    end
  end

  initial begin
    pc = 3'h0;
    rst(1'b0);
    wb(1'b0, ADR_CTRL, 32'h0);
    check("ctrl_rst", rd, {27'h0, PCLASS_RST, RESUME_EN_RST, LINK_CONTROL_RST});
    wb(1'b0, 8'h0C, 32'h0);
    check("unmapped", rd, 32'h0);
    check("link_on", link_active, 1'b1);
    for (int j = 0; j < 8; j++) begin
      wb(1'b1, ADR_CTRL, {30'h0, j[0], 1'b0});
      ev(j >> 1);
      watch(24);
      check("irq_wake", hit, exp_irq(j >> 1, j[0]));
      wb(1'b1, ADR_IRQ, 32'hF);
      watch(40);
      check("wake_holds", hit, exp_irq(j >> 1, j[0]));
      stop_check();
    end
    for (int i = 0; i < 6; i++) begin
      pc = (i == 0) ? 3'h4 : (i == 1) ? 3'h5 : 3'($random(seed));
      wb(1'b1, ADR_CTRL, {27'h0, pc, 2'b00});
      ev(6);
      watch(24);
      check("pwr_wake", hit, exp_pwr(pc));
      stop_check();
    end
    wb(1'b1, ADR_CTRL, {27'h0, pc, 2'b00});
    ev(4);
    hit = 1'b0;
    for (int k = 0; k < 40 && wake_link_out !== 1'b1; k++) @(negedge clk);
    for (int k = 0; k < WAKE_PERIOD_PCLK * PCLK_DIV_CYCLES; k++) begin
      check("wave", wake_link_out, k < WAKE_HIGH_PCLK * PCLK_DIV_CYCLES);
      @(negedge clk);
    end
    wb(1'b0, ADR_STATUS, 32'h0);
    check("stat_wake", rd[STAT_WAKE], 1'b1);
    check("stat_pkt", rd[STAT_PKT_CAUSE], 1'b1);
    ev(5);
    watch(40);
    check("bus_rst_pkt", hit, 1'b0);
    ev(0);
    watch(20);
    ev(5);
    watch(40);
    check("bus_rst_irq", hit, 1'b1);
    stop_check();
    @(posedge clk);
    sleep <= 1'b1;
    delay <= 8'h14 + {2'b00, 6'($random(seed))};
    @(posedge clk);
    sleep <= 1'b0;
    repeat (INACT + 6) @(negedge clk);
    check("sense_off", link_active, 1'b0);
    ev(4);
    watch(160);
    check("pkt_wake", hit, 1'b1);
    check("link_back", link_active, 1'b1);
    check("out_idle", wake_link_out, 1'b0);
    rst(1'b1);
    results();
  end
endmodule : tb_lkw_wake_top
